// [core/cnpx_core.sv]
// executor for dispatch, no-operation, logical or and stack pop behind an ahb-lite slave
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "cnpx_regs.svh"
module cnpx_core
  import cnpx_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             busy
);

  cnpx_core_t  cur_r;
  cnpx_core_t  cur_nxt;

  cnpx_op_t    opClass;
  logic [4:0]  opCycles;
  logic [15:0] opLength;
  logic [7:0]  opcode;
  logic [7:0]  byte2;
  logic [7:0]  byte3;
  logic [7:0]  orDstAddr;
  logic [7:0]  orSrcVal;
  logic [7:0]  orResult;
  logic [7:0]  orFlags;
  logic [7:0]  popDstAddr;
  logic [31:0] rdVal;
  logic        addrPhase;
  logic        goWrite;

  // address of working register n
  function automatic logic [7:0] workAddr(input logic [3:0] n);
    workAddr = {workAddrHigh(), n};
  endfunction

  // high nibble of the working register block
  function automatic logic [3:0] workAddrHigh();
    logic [7:0] base;
    base         = `CNPX_WORK_BASE;
    workAddrHigh = base[7:4];
  endfunction

  assign opcode = cur_r.instr[7:0];
  assign byte2  = cur_r.instr[15:8];
  assign byte3  = cur_r.instr[23:16];

  // decode of the latched instruction
  cnpx_opdec u_opdec
  (
    .opcode  (opcode),
    .opClass (opClass),
    .cycles  (opCycles),
    .length  (opLength)
  );

  // operand fetch for or; the source is only read, never written
  always_comb
  begin
    orDstAddr = byte3;
    orSrcVal  = 8'h00;
    unique case (opcode)
      `CNPX_OPC_OR_WW:
      begin
        orDstAddr = workAddr(byte2[7:4]);
        orSrcVal  = cur_r.rf[workAddr(byte2[3:0])];
      end
      `CNPX_OPC_OR_WIW:
      begin
        orDstAddr = workAddr(byte2[7:4]);
        orSrcVal  = cur_r.rf[cur_r.rf[workAddr(byte2[3:0])]];
      end
      `CNPX_OPC_OR_GG:
        orSrcVal  = cur_r.rf[byte2];
      `CNPX_OPC_OR_GIG:
        orSrcVal  = cur_r.rf[cur_r.rf[byte2]];
      `CNPX_OPC_OR_GIM:
        orSrcVal  = byte2;
      default:
        orSrcVal  = 8'h00;
    endcase
  end

  // destination of pop, direct or through a register
  assign popDstAddr = (opcode == `CNPX_OPC_POP_IG) ? cur_r.rf[byte2] : byte2;

  cnpx_or_alu u_or_alu
  (
    .dstVal   (cur_r.rf[orDstAddr]),
    .srcVal   (orSrcVal),
    .flagsIn  (cur_r.flags),
    .result   (orResult),
    .flagsOut (orFlags)
  );

  // register read multiplexer, unmapped offsets read zero
  always_comb
  begin
    rdVal = 32'h0000_0000;
    unique case (cur_r.rdAddr)
      `CNPX_OFS_INSTR:  rdVal = {8'h00, cur_r.instr};
      `CNPX_OFS_STATUS:
      begin
        rdVal[`CNPX_STAT_BUSY]    = cur_r.st[1];
        rdVal[`CNPX_STAT_ILLEGAL] = cur_r.illegal;
      end
      `CNPX_OFS_PC:     rdVal = {16'h0000, cur_r.pc};
      `CNPX_OFS_TPTR:   rdVal = {16'h0000, cur_r.tptr};
      `CNPX_OFS_SPTR:   rdVal = {16'h0000, cur_r.sptr};
      `CNPX_OFS_FLAGS:  rdVal = {24'h00_0000, cur_r.flags};
      `CNPX_OFS_RFADDR: rdVal = {24'h00_0000, cur_r.rfAddr};
      `CNPX_OFS_RFDATA: rdVal = {24'h00_0000, cur_r.rf[cur_r.rfAddr]};
      `CNPX_OFS_PMADDR: rdVal = {28'h000_0000, cur_r.pmAddr};
      `CNPX_OFS_PMDATA: rdVal = {16'h0000, cur_r.pm[cur_r.pmAddr]};
      default:          rdVal = 32'h0000_0000;
    endcase
  end

  assign addrPhase = hsel && htrans[1] && hready;
  assign goWrite   = cur_r.wrPend && (cur_r.wrAddr == `CNPX_OFS_CTRL)
                     && hwdata[`CNPX_CTRL_GO];

  // next state: bus slave, software writes, execution
  always_comb
  begin
    cur_nxt        = cur_r;
    cur_nxt.wrPend = 1'b0;
    cur_nxt.hready = 1'b1;
    cur_nxt.hresp  = 1'b0;

    // read data phase: one wait cycle, then data with hready
    if (cur_r.rdPend)
    begin
      cur_nxt.hrdata = rdVal;
      cur_nxt.rdPend = 1'b0;
    end

    // write data phase; state registers are locked while busy
    if (cur_r.wrPend && (cur_r.st == CNPX_IDLE))
    begin
      unique case (cur_r.wrAddr)
        `CNPX_OFS_INSTR:  cur_nxt.instr  = hwdata[23:0];
        `CNPX_OFS_PC:     cur_nxt.pc     = hwdata[15:0];
        `CNPX_OFS_TPTR:   cur_nxt.tptr   = hwdata[15:0];
        `CNPX_OFS_SPTR:   cur_nxt.sptr   = hwdata[15:0];
        `CNPX_OFS_FLAGS:  cur_nxt.flags  = hwdata[7:0];
        `CNPX_OFS_RFADDR: cur_nxt.rfAddr = hwdata[7:0];
        `CNPX_OFS_RFDATA: cur_nxt.rf[cur_r.rfAddr] = hwdata[7:0];
        `CNPX_OFS_PMADDR: cur_nxt.pmAddr = hwdata[3:0];
        `CNPX_OFS_PMDATA: cur_nxt.pm[cur_r.pmAddr] = hwdata[15:0];
        default:          cur_nxt.hresp  = 1'b0;
      endcase
    end

    // address phase capture
    if (addrPhase)
    begin
      if (hwrite)
      begin
        cur_nxt.wrPend = 1'b1;
        cur_nxt.wrAddr = haddr[7:0];
      end
      else
      begin
        cur_nxt.rdPend = 1'b1;
        cur_nxt.rdAddr = haddr[7:0];
        cur_nxt.hready = 1'b0;
      end
    end

    // execution sequencer
    unique case (cur_r.st)
      CNPX_IDLE:
      begin
        if (goWrite)
        begin
          if (opClass == CNPX_OP_BAD)
            cur_nxt.illegal = 1'b1;
          else
          begin
            cur_nxt.illegal = 1'b0;
            cur_nxt.cnt     = opCycles;
            cur_nxt.st      = CNPX_RUN;
          end
        end
      end
      CNPX_RUN:
      begin
        cur_nxt.cnt = cur_r.cnt - 5'h01;
        if (cur_r.cnt == 5'h01)
        begin
          cur_nxt.st = CNPX_IDLE;
          cur_nxt.pc = cur_r.pc + opLength;
          unique case (opClass)
            CNPX_OP_NEXT:
            begin
              cur_nxt.pc   = cur_r.pm[cur_r.tptr[4:1]];
              cur_nxt.tptr = cur_r.tptr + `CNPX_TPTR_STEP;
            end
            CNPX_OP_OR:
            begin
              cur_nxt.rf[orDstAddr] = orResult;
              cur_nxt.flags         = orFlags;
            end
            CNPX_OP_POP:
            begin
              cur_nxt.rf[popDstAddr] = cur_r.rf[cur_r.sptr[7:0]];
              cur_nxt.sptr           = cur_r.sptr + `CNPX_SPTR_STEP;
            end
            default:
              cur_nxt.flags = cur_r.flags;
          endcase
        end
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur_r        <= '0;
      cur_r.st     <= CNPX_IDLE;
      cur_r.pc     <= `CNPX_RST_PC;
      cur_r.tptr   <= `CNPX_RST_TPTR;
      cur_r.sptr   <= `CNPX_RST_SPTR;
      cur_r.flags  <= `CNPX_RST_FLAGS;
      cur_r.hready <= 1'b1;
    end
    else
      cur_r <= cur_nxt;
  end

  // outputs straight from the state register
  assign hreadyout = cur_r.hready;
  assign hresp     = cur_r.hresp;
  assign hrdata    = cur_r.hrdata;
  assign busy      = cur_r.st[1];

endmodule

// [core/cnpx_regs.svh]
// register offsets, field positions, reset values and cycle counts of the executor
`ifndef CNPX_REGS_SVH
`define CNPX_REGS_SVH

// register byte offsets on the bus
`define CNPX_OFS_CTRL     8'h00
`define CNPX_OFS_INSTR    8'h04
`define CNPX_OFS_STATUS   8'h08
`define CNPX_OFS_PC       8'h0C
`define CNPX_OFS_TPTR     8'h10
`define CNPX_OFS_SPTR     8'h14
`define CNPX_OFS_FLAGS    8'h18
`define CNPX_OFS_RFADDR   8'h1C
`define CNPX_OFS_RFDATA   8'h20
`define CNPX_OFS_PMADDR   8'h24
`define CNPX_OFS_PMDATA   8'h28

// field positions
`define CNPX_CTRL_GO      0
`define CNPX_STAT_BUSY    0
`define CNPX_STAT_ILLEGAL 1
`define CNPX_FLAG_C       7
`define CNPX_FLAG_Z       6
`define CNPX_FLAG_S       5
`define CNPX_FLAG_V       4
`define CNPX_FLAG_D       3
`define CNPX_FLAG_H       2

// reset values
`define CNPX_RST_PC       16'h0000
`define CNPX_RST_TPTR     16'h0000
`define CNPX_RST_SPTR     16'h0000
`define CNPX_RST_FLAGS    8'h00

// base of the sixteen working registers
`define CNPX_WORK_BASE    8'hC0

// opcodes
`define CNPX_OPC_NEXT     8'h0F
`define CNPX_OPC_NOP      8'hFF
`define CNPX_OPC_OR_WW    8'h42
`define CNPX_OPC_OR_WIW   8'h43
`define CNPX_OPC_OR_GG    8'h44
`define CNPX_OPC_OR_GIG   8'h45
`define CNPX_OPC_OR_GIM   8'h46
`define CNPX_OPC_POP_G    8'h50
`define CNPX_OPC_POP_IG   8'h51

// execution times in core cycles
`define CNPX_CYC_NEXT     5'h0A
`define CNPX_CYC_NOP      5'h04
`define CNPX_CYC_OR_SHORT 5'h04
`define CNPX_CYC_OR_LONG  5'h06
`define CNPX_CYC_POP      5'h08

// instruction lengths in bytes
`define CNPX_LEN_ONE      16'h0001
`define CNPX_LEN_TWO      16'h0002
`define CNPX_LEN_THREE    16'h0003

// thread pointer and stack pointer steps
`define CNPX_TPTR_STEP    16'h0002
`define CNPX_SPTR_STEP    16'h0001

`endif

// [core/cnpx_pkg.sv]
// types shared by the executor modules
package cnpx_pkg;

  typedef enum logic [1:0] {
    CNPX_IDLE = 2'b01,
    CNPX_RUN  = 2'b10
  } cnpx_fsm_t;

  typedef enum logic [2:0] {
    CNPX_OP_BAD  = 3'h0,
    CNPX_OP_NEXT = 3'h1,
    CNPX_OP_NOP  = 3'h2,
    CNPX_OP_OR   = 3'h3,
    CNPX_OP_POP  = 3'h4
  } cnpx_op_t;

  typedef struct packed {
    cnpx_fsm_t         st;
    logic [4:0]        cnt;
    logic [23:0]       instr;
    logic [15:0]       pc;
    logic [15:0]       tptr;
    logic [15:0]       sptr;
    logic [7:0]        flags;
    logic              illegal;
    logic [7:0]        rfAddr;
    logic [3:0]        pmAddr;
    logic [255:0][7:0] rf;
    logic [15:0][15:0] pm;
    logic              wrPend;
    logic [7:0]        wrAddr;
    logic              rdPend;
    logic [7:0]        rdAddr;
    logic [31:0]       hrdata;
    logic              hready;
    logic              hresp;
  } cnpx_core_t;

endpackage

// [core/cnpx_opdec.sv]
// opcode decoder: operation class, execution cycles and length
`timescale 1ns/1ps
`include "cnpx_regs.svh"
module cnpx_opdec
  import cnpx_pkg::*;
(
  input  wire logic [7:0]  opcode,
  output cnpx_op_t         opClass,
  output logic [4:0]       cycles,
  output logic [15:0]      length
);

  // classify the opcode and give its timing
  always_comb
  begin
    opClass = CNPX_OP_BAD;
    cycles  = 5'h00;
    length  = `CNPX_LEN_ONE;
    unique case (opcode)
      `CNPX_OPC_NEXT:
      begin
        opClass = CNPX_OP_NEXT;
        cycles  = `CNPX_CYC_NEXT;
      end
      `CNPX_OPC_NOP:
      begin
        opClass = CNPX_OP_NOP;
        cycles  = `CNPX_CYC_NOP;
      end
      `CNPX_OPC_OR_WW:
      begin
        opClass = CNPX_OP_OR;
        cycles  = `CNPX_CYC_OR_SHORT;
        length  = `CNPX_LEN_TWO;
      end
      `CNPX_OPC_OR_WIW:
      begin
        opClass = CNPX_OP_OR;
        cycles  = `CNPX_CYC_OR_LONG;
        length  = `CNPX_LEN_TWO;
      end
      `CNPX_OPC_OR_GG, `CNPX_OPC_OR_GIG, `CNPX_OPC_OR_GIM:
      begin
        opClass = CNPX_OP_OR;
        cycles  = `CNPX_CYC_OR_LONG;
        length  = `CNPX_LEN_THREE;
      end
      `CNPX_OPC_POP_G, `CNPX_OPC_POP_IG:
      begin
        opClass = CNPX_OP_POP;
        cycles  = `CNPX_CYC_POP;
        length  = `CNPX_LEN_TWO;
      end
      default:
      begin
        opClass = CNPX_OP_BAD;
        cycles  = 5'h00;
        length  = `CNPX_LEN_ONE;
      end
    endcase
  end

endmodule

// [core/cnpx_or_alu.sv]
// bitwise or of two bytes with its flag update
`timescale 1ns/1ps
`include "cnpx_regs.svh"
module cnpx_or_alu
  import cnpx_pkg::*;
(
  input  wire logic [7:0] dstVal,
  input  wire logic [7:0] srcVal,
  input  wire logic [7:0] flagsIn,
  output logic [7:0]      result,
  output logic [7:0]      flagsOut
);

  // result and flags; carry, decimal and half carry pass through
  always_comb
  begin
    result                  = dstVal | srcVal;
    flagsOut                = flagsIn;
    flagsOut[`CNPX_FLAG_Z]  = (result == 8'h00);
    flagsOut[`CNPX_FLAG_S]  = result[7];
    flagsOut[`CNPX_FLAG_V]  = 1'b0;
  end

endmodule

// [sim/cnpx_core_chk.sv]
// concurrent checks on the executor's bus timing and execution lengths
`timescale 1ns/1ps
`include "cnpx_regs.svh"
module cnpx_core_chk
  import cnpx_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        busy
);
  logic       take;
  logic       go;
  logic       phV_r;
  logic       phW_r;
  logic [7:0] phA_r;
  logic [7:0] opc_r;

  // address phase taken, and an accepted start command in its data phase
  assign take = hsel && htrans[1] && hready;
  assign go   = phV_r && phW_r && hready && !busy && phA_r == `CNPX_OFS_CTRL && hwdata[0];

  // track the data phase and the last opcode accepted while idle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      phV_r <= 1'b0;
      phW_r <= 1'b0;
      phA_r <= 8'h00;
      opc_r <= 8'h00;
    end
    else
    begin
      if (hready)
      begin
        phV_r <= take;
        phW_r <= hwrite;
        phA_r <= haddr[7:0];
      end
      if (phV_r && phW_r && hready && !busy && phA_r == `CNPX_OFS_INSTR)
        opc_r <= hwdata[7:0];
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_next_len: assert property (
    go && opc_r == `CNPX_OPC_NEXT |=> busy[*8] ##1 busy[*2] ##1 !busy)
    else $error("dispatch busy length wrong");
  a_nop_len: assert property (
    go && opc_r == `CNPX_OPC_NOP |=> busy[*4] ##1 !busy)
    else $error("no-op busy length wrong");
  a_or_short: assert property (
    go && opc_r == `CNPX_OPC_OR_WW |=> busy[*4] ##1 !busy)
    else $error("short or busy length wrong");
  a_or_long: assert property (
    go && opc_r inside {8'h43, 8'h44, 8'h45, 8'h46} |=> busy[*6] ##1 !busy)
    else $error("long or busy length wrong");
  a_pop_len: assert property (
    go && opc_r inside {8'h50, 8'h51} |=> busy[*8] ##1 !busy)
    else $error("pop busy length wrong");
  a_rd_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_wr_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  a_resp_okay: assert property (phV_r |-> !hresp)
    else $error("response not okay");
endmodule
bind cnpx_core cnpx_core_chk chk (
  .clk_sys   (clk_sys),
  .rst       (rst),
  .hsel      (hsel),
  .haddr     (haddr),
  .htrans    (htrans),
  .hwrite    (hwrite),
  .hready    (hready),
  .hwdata    (hwdata),
  .hreadyout (hreadyout),
  .hresp     (hresp),
  .busy      (busy)
);

// [sim/cpu_next_nop_or_pop_exec_tb_top.sv]
// self-checking bench driving the executor over ahb-lite
`timescale 1ns/1ps
`include "cnpx_regs.svh"
module cpu_next_nop_or_pop_exec_tb_top
  import cnpx_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        busy;
  logic [31:0] q;
  int          n;
  int          failCount = 0;
  int          checked = 0;

  cnpx_core dut (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'b010),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .busy      (busy)
  );

  // 50 ns core clock
  initial
    forever #25 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one single transfer; ready and read data taken at the rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic setrf(input logic [7:0] a, input logic [7:0] v);
    wr(`CNPX_OFS_RFADDR, 32'(a));
    wr(`CNPX_OFS_RFDATA, 32'(v));
  endtask

  task automatic rfc(input logic [7:0] a, input logic [7:0] e);
    wr(`CNPX_OFS_RFADDR, 32'(a));
    rdc(`CNPX_OFS_RFDATA, 32'(e));
  endtask

  // load and start one instruction, then count its busy cycles
  task automatic run(input logic [23:0] ins);
    wr(`CNPX_OFS_INSTR, 32'(ins));
    wr(`CNPX_OFS_CTRL, 32'h0000_0001);
    n = 0;
    @(negedge clk_sys);
    while (busy === 1'b1)
    begin
      n++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask

  // or with preset flags; checks length, result and flags
  task automatic orchk(input logic [23:0] ins, input logic [7:0] fpre, input logic [7:0] dst,
                       input logic [7:0] e, input logic [7:0] fexp, input int cyc);
    wr(`CNPX_OFS_FLAGS, 32'(fpre));
    run(ins);
    chk(n, cyc);
    rfc(dst, e);
    rdc(`CNPX_OFS_FLAGS, 32'(fexp));
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    #1_000_000;
    failCount++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rdc(`CNPX_OFS_PC, 32'h0000_0000);
    rdc(8'h30, 32'h0000_0000);
    // dispatch twice back to back
    wr(`CNPX_OFS_PMADDR, 32'h0000_0000);
    wr(`CNPX_OFS_PMDATA, 32'h0000_1234);
    wr(`CNPX_OFS_PMADDR, 32'h0000_0001);
    wr(`CNPX_OFS_PMDATA, 32'h0000_BEEF);
    wr(`CNPX_OFS_FLAGS, 32'h0000_00A4);
    run(24'h00_000F);
    chk(n, 10);
    rdc(`CNPX_OFS_PC, 32'h0000_1234);
    rdc(`CNPX_OFS_TPTR, 32'h0000_0002);
    run(24'h00_000F);
    rdc(`CNPX_OFS_PC, 32'h0000_BEEF);
    rdc(`CNPX_OFS_TPTR, 32'h0000_0004);
    rdc(`CNPX_OFS_FLAGS, 32'h0000_00A4);
    // no-op leaves everything but the program counter
    wr(`CNPX_OFS_SPTR, 32'h0000_00FB);
    run(24'h00_00FF);
    chk(n, 4);
    rdc(`CNPX_OFS_PC, 32'h0000_BEF0);
    rdc(`CNPX_OFS_TPTR, 32'h0000_0004);
    rdc(`CNPX_OFS_SPTR, 32'h0000_00FB);
    rdc(`CNPX_OFS_FLAGS, 32'h0000_00A4);
    // or in all five addressing forms
    setrf(8'hC0, 8'h15);
    setrf(8'hC1, 8'h2A);
    setrf(8'hC2, 8'h20);
    setrf(8'hC3, 8'h02);
    setrf(8'h20, 8'h41);
    setrf(8'h21, 8'h20);
    setrf(8'h22, 8'h08);
    orchk(24'h00_0142, 8'hFC, 8'hC0, 8'h3F, 8'h8C, 4);
    orchk(24'h00_3243, 8'h10, 8'hC3, 8'h43, 8'h00, 6);
    orchk(24'h11_1244, 8'h10, 8'h11, 8'h00, 8'h40, 6);
    orchk(24'h22_2145, 8'h70, 8'h22, 8'h49, 8'h00, 6);
    orchk(24'h10_8046, 8'h00, 8'h10, 8'h80, 8'h20, 6);
    rfc(8'hC1, 8'h2A);
    rfc(8'hC2, 8'h20);
    rfc(8'h20, 8'h41);
    rfc(8'h21, 8'h20);
    // pop direct and indirect
    setrf(8'hFB, 8'h55);
    setrf(8'hFC, 8'h66);
    setrf(8'h06, 8'h07);
    run(24'h00_0550);
    chk(n, 8);
    rfc(8'h05, 8'h55);
    rdc(`CNPX_OFS_SPTR, 32'h0000_00FC);
    run(24'h00_0651);
    rfc(8'h07, 8'h66);
    rdc(`CNPX_OFS_SPTR, 32'h0000_00FD);
    rdc(`CNPX_OFS_FLAGS, 32'h0000_0020);
    give_verdict();
  end
endmodule
